// ### pefi_flags.sv
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`default_nettype none
// Function
// - bit 15 latches on link quality change with link up; enable bit 7 gates it
// - bit 14 latches on energy detect change; enable bit 6 gates it
// - bit 13 latches on link status change; enable bit 5 gates it
// - bit 12 latches on wake frame detection; enable bit 4 gates it
// - bit 11 latches on electrostatic discharge, else stays zero; enable bit 3
// - bit 10 latches on training completion; enable bit 2 gates it
// - bit 9 latches when false carrier count exceeds half; enable bit 1
// - bit 8 latches when receive error count exceeds half; enable bit 0
// - secondary flags 15,14,11..8 read-only, latched, reset zero; 13:12 reserved
// - receive error counter half event above 0x7fff, stops at maximum
// - polarity bit 1 idles pin high, low on interrupt; 0 the reverse
// - test bit forces the interrupt for as long as it stays set
module pefi_flags
(
	input  wire logic                    core_clk,
	input  wire logic                    sys_rst,
	input  wire pefi_pkg::pefi_evt_t     evt,
	input  wire pefi_pkg::pefi_sec_evt_t sec_evt,
	input  wire logic                    false_carrier_evt,
	input  wire logic                    rx_error_evt,
	output var  logic                    int_pin_reg,
	input  wire logic [7:0]              s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output var  logic                    s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output var  logic                    s_axi_wready,
	output var  logic [1:0]              s_axi_bresp,
	output var  logic                    s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [7:0]              s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output var  logic                    s_axi_arready,
	output var  logic [31:0]             s_axi_rdata,
	output var  logic [1:0]              s_axi_rresp,
	output var  logic                    s_axi_rvalid,
	input  wire logic                    s_axi_rready
);
	// ************************************************************
	// declarations
	// ************************************************************
	logic [7:0]         pri_flags;
	logic [7:0]         sec_flags;
	logic [7:0]         pri_ev;
	logic [7:0]         sec_ev;
	logic [7:0]         pri_en_reg;
	logic [7:0]         pri_en_next;
	logic [7:0]         sec_en_reg;
	logic [7:0]         sec_en_next;
	logic [15:0]        test_reg;
	logic [15:0]        test_next;
	logic [7:0]         fc_count;
	logic [15:0]        re_count;
	logic               fc_half;
	logic               re_half;
	logic               rd_clr_pri;
	logic               rd_clr_sec;
	logic               rd_clr_fc;
	logic               rd_clr_re;
	logic               aw_have_reg;
	logic               aw_have_next;
	logic               w_have_reg;
	logic               w_have_next;
	logic [5:0]         wr_idx_reg;
	logic [5:0]         wr_idx_next;
	logic [31:0]        wdata_reg;
	logic [31:0]        wdata_next;
	logic [3:0]         wstrb_reg;
	logic [3:0]         wstrb_next;
	logic               awready_reg;
	logic               awready_next;
	logic               wready_reg;
	logic               wready_next;
	logic               bvalid_reg;
	logic               bvalid_next;
	logic [1:0]         bresp_reg;
	logic [1:0]         bresp_next;
	logic               do_write;
	logic               wr_hit;
	pefi_pkg::pefi_rd_t rd_state_reg;
	pefi_pkg::pefi_rd_t rd_state_next;
	logic               arready_reg;
	logic               arready_next;
	logic               rvalid_reg;
	logic               rvalid_next;
	logic [31:0]        rdata_reg;
	logic [31:0]        rdata_next;
	logic [1:0]         rresp_reg;
	logic [1:0]         rresp_next;
	logic               ar_take;
	logic [5:0]         rd_idx;
	logic               irq_act;
	logic               int_pin_next;
	logic               pol_bit;

	// ************************************************************
	// event sources and flag latches
	// ************************************************************
	assign pri_ev = {evt, fc_half, re_half};
	assign sec_ev = {sec_evt.undervolt, sec_evt.overvolt, 2'b00, sec_evt.overtemp,
		sec_evt.sleep, sec_evt.polarity, sec_evt.jabber};

	pefi_flag_bank u_pri_bank
	(
		.core_clk  (core_clk),
		.sys_rst   (sys_rst),
		.present   (pri_ev),
		.mask      (pefi_pkg::PRI_MASK),
		.rd_clr    (rd_clr_pri),
		.flags_reg (pri_flags)
	);

	pefi_flag_bank u_sec_bank
	(
		.core_clk  (core_clk),
		.sys_rst   (sys_rst),
		.present   (sec_ev),
		.mask      (pefi_pkg::SEC_MASK),
		.rd_clr    (rd_clr_sec),
		.flags_reg (sec_flags)
	);

	pefi_sat_counter #(.W(pefi_pkg::FCC_W), .HALF(pefi_pkg::FCC_HALF)) u_fc_cnt
	(
		.core_clk  (core_clk),
		.sys_rst   (sys_rst),
		.inc       (false_carrier_evt),
		.rd_clr    (rd_clr_fc),
		.count_reg (fc_count),
		.half      (fc_half)
	);

	pefi_sat_counter #(.W(pefi_pkg::REC_W), .HALF(pefi_pkg::REC_HALF)) u_re_cnt
	(
		.core_clk  (core_clk),
		.sys_rst   (sys_rst),
		.inc       (rx_error_evt),
		.rd_clr    (rd_clr_re),
		.count_reg (re_count),
		.half      (re_half)
	);

	// ************************************************************
	// write channel
	// ************************************************************
	assign wr_hit = wr_idx_reg >= pefi_pkg::IDX_TEST && wr_idx_reg <= pefi_pkg::IDX_REC;

	always_comb
	begin
		aw_have_next = aw_have_reg;
		w_have_next  = w_have_reg;
		wr_idx_next  = wr_idx_reg;
		wdata_next   = wdata_reg;
		wstrb_next   = wstrb_reg;
		bvalid_next  = bvalid_reg;
		bresp_next   = bresp_reg;
		do_write     = 1'b0;
		if (s_axi_awvalid && awready_reg)
		begin
			aw_have_next = 1'b1;
			wr_idx_next  = s_axi_awaddr[pefi_pkg::ADDR_W-1:pefi_pkg::IDX_LSB];
		end
		if (s_axi_wvalid && wready_reg)
		begin
			w_have_next = 1'b1;
			wdata_next  = s_axi_wdata;
			wstrb_next  = s_axi_wstrb;
		end
		if (bvalid_reg && s_axi_bready)
			bvalid_next = 1'b0;
		if (aw_have_reg && w_have_reg && !bvalid_reg)
		begin
			do_write     = 1'b1;
			aw_have_next = 1'b0;
			w_have_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = wr_hit ? pefi_pkg::RESP_OKAY : pefi_pkg::RESP_SLVERR;
		end
		awready_next = !aw_have_next && !bvalid_next;
		wready_next  = !w_have_next && !bvalid_next;
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			aw_have_reg <= 1'b0;
			w_have_reg  <= 1'b0;
			wr_idx_reg  <= 6'h00;
			wdata_reg   <= 32'h0000_0000;
			wstrb_reg   <= 4'h0;
			awready_reg <= 1'b0;
			wready_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= pefi_pkg::RESP_OKAY;
		end
		else
		begin
			aw_have_reg <= aw_have_next;
			w_have_reg  <= w_have_next;
			wr_idx_reg  <= wr_idx_next;
			wdata_reg   <= wdata_next;
			wstrb_reg   <= wstrb_next;
			awready_reg <= awready_next;
			wready_reg  <= wready_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
		end
	end

	// ************************************************************
	// control registers
	// ************************************************************
	always_comb
	begin
		pri_en_next = pri_en_reg;
		sec_en_next = sec_en_reg;
		test_next   = test_reg;
		if (do_write && wstrb_reg[0])
		begin
			if (wr_idx_reg == pefi_pkg::IDX_PRI)
				pri_en_next = wdata_reg[7:0];
			if (wr_idx_reg == pefi_pkg::IDX_SEC)
				sec_en_next = wdata_reg[7:0] & pefi_pkg::SEC_MASK;
			if (wr_idx_reg == pefi_pkg::IDX_TEST)
				test_next[7:0] = wdata_reg[7:0];
		end
		if (do_write && wstrb_reg[1] && wr_idx_reg == pefi_pkg::IDX_TEST)
			test_next[15:8] = wdata_reg[15:8];
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			pri_en_reg <= pefi_pkg::EN_RST;
			sec_en_reg <= pefi_pkg::EN_RST;
			test_reg   <= pefi_pkg::TEST_RST;
		end
		else
		begin
			pri_en_reg <= pri_en_next;
			sec_en_reg <= sec_en_next;
			test_reg   <= test_next;
		end
	end

	// ************************************************************
	// read channel
	// ************************************************************
	assign ar_take    = s_axi_arvalid && arready_reg;
	assign rd_idx     = s_axi_araddr[pefi_pkg::ADDR_W-1:pefi_pkg::IDX_LSB];
	assign rd_clr_pri = ar_take && rd_idx == pefi_pkg::IDX_PRI;
	assign rd_clr_sec = ar_take && rd_idx == pefi_pkg::IDX_SEC;
	assign rd_clr_fc  = ar_take && rd_idx == pefi_pkg::IDX_FCC;
	assign rd_clr_re  = ar_take && rd_idx == pefi_pkg::IDX_REC;

	always_comb
	begin
		rd_state_next = rd_state_reg;
		arready_next  = arready_reg;
		rvalid_next   = rvalid_reg;
		rdata_next    = rdata_reg;
		rresp_next    = rresp_reg;
		unique case (rd_state_reg)
			pefi_pkg::RD_IDLE:
			begin
				arready_next = 1'b1;
				if (ar_take)
				begin
					arready_next  = 1'b0;
					rvalid_next   = 1'b1;
					rresp_next    = pefi_pkg::RESP_OKAY;
					rd_state_next = pefi_pkg::RD_DATA;
					case (rd_idx)
						pefi_pkg::IDX_TEST: rdata_next = {16'h0000, test_reg};
						pefi_pkg::IDX_PRI:  rdata_next = {16'h0000, pri_flags, pri_en_reg};
						pefi_pkg::IDX_SEC:  rdata_next = {16'h0000, sec_flags, sec_en_reg};
						pefi_pkg::IDX_FCC:  rdata_next = {24'h000000, fc_count};
						pefi_pkg::IDX_REC:  rdata_next = {16'h0000, re_count};
						default:
						begin
							rdata_next = 32'h0000_0000;
							rresp_next = pefi_pkg::RESP_SLVERR;
						end
					endcase
				end
			end
			pefi_pkg::RD_DATA:
			begin
				if (s_axi_rready)
				begin
					rvalid_next   = 1'b0;
					arready_next  = 1'b1;
					rd_state_next = pefi_pkg::RD_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			rd_state_reg <= pefi_pkg::RD_IDLE;
			arready_reg  <= 1'b0;
			rvalid_reg   <= 1'b0;
			rdata_reg    <= 32'h0000_0000;
			rresp_reg    <= pefi_pkg::RESP_OKAY;
		end
		else
		begin
			rd_state_reg <= rd_state_next;
			arready_reg  <= arready_next;
			rvalid_reg   <= rvalid_next;
			rdata_reg    <= rdata_next;
			rresp_reg    <= rresp_next;
		end
	end

	// ************************************************************
	// interrupt pin
	// ************************************************************
	assign pol_bit = test_reg[pefi_pkg::POL_BIT];

	always_comb
	begin
		irq_act = (|(pri_flags & pri_en_reg)) | (|(sec_flags & sec_en_reg))
			| test_reg[pefi_pkg::FORCE_BIT];
		int_pin_next = irq_act ^ pol_bit;
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			int_pin_reg <= pefi_pkg::TEST_RST[pefi_pkg::POL_BIT];
		else
			int_pin_reg <= int_pin_next;
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready  = wready_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	property p_lq_latch;
		evt.link_quality |=> pri_flags[7];
	endproperty
	a_lq_latch: assert property (p_lq_latch) else $error("link quality flag missed");

	property p_esd_quiet;
		!pri_flags[3] && !evt.esd |=> !pri_flags[3];
	endproperty
	a_esd_quiet: assert property (p_esd_quiet) else $error("esd flag set without event");

	property p_fc_half;
		fc_count > 8'h7f |=> pri_flags[1];
	endproperty
	a_fc_half: assert property (p_fc_half) else $error("false carrier half flag missed");

	property p_re_half;
		re_count > 16'h7fff |=> pri_flags[0];
	endproperty
	a_re_half: assert property (p_re_half) else $error("rx error half flag missed");

	property p_jabber;
		sec_evt.jabber |=> sec_flags[0] && sec_flags[5:4] == 2'b00;
	endproperty
	a_jabber: assert property (p_jabber) else $error("jabber flag wrong");

	property p_sec_rsv;
		sec_en_reg[5:4] == 2'b00;
	endproperty
	a_sec_rsv: assert property (p_sec_rsv) else $error("reserved enable bits set");

	property p_fc_sat;
		fc_count == 8'hff && !rd_clr_fc |=> fc_count == 8'hff;
	endproperty
	a_fc_sat: assert property (p_fc_sat) else $error("false carrier counter wrapped");

	property p_sticky;
		pri_flags[5] && !rd_clr_pri |=> pri_flags[5];
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag dropped without read");

	property p_rd_clear;
		pri_flags[4] && rd_clr_pri && !evt.wake_frame |=> !pri_flags[4] ##1 (!pri_flags[4] || $past(evt.wake_frame));
	endproperty
	a_rd_clear: assert property (p_rd_clear) else $error("read did not clear flag");

	property p_irq_on;
		irq_act |=> int_pin_reg == !$past(pol_bit);
	endproperty
	a_irq_on: assert property (p_irq_on) else $error("pin not active on interrupt");

	property p_irq_idle;
		!irq_act |=> int_pin_reg == $past(pol_bit);
	endproperty
	a_irq_idle: assert property (p_irq_idle) else $error("pin not idle");

	property p_force;
		test_reg[2] [*3] |-> ##1 int_pin_reg != pol_bit || $changed(pol_bit);
	endproperty
	a_force: assert property (p_force) else $error("forced interrupt not held");

	c_write: cover property (do_write && wr_idx_reg == pefi_pkg::IDX_PRI);
	c_read_clr: cover property (rd_clr_pri && pri_flags != 8'h00);
	c_irq: cover property (!irq_act ##1 irq_act);
endmodule
`default_nettype wire

// ### pefi_pkg.sv
`default_nettype none
// ************************************************************
// register map, layouts and reset values
// ************************************************************
package pefi_pkg;
	// register indexes; byte address is four times the index
	localparam logic [5:0]  IDX_TEST   = 6'h11;
	localparam logic [5:0]  IDX_PRI    = 6'h12;
	localparam logic [5:0]  IDX_SEC    = 6'h13;
	localparam logic [5:0]  IDX_FCC    = 6'h14;
	localparam logic [5:0]  IDX_REC    = 6'h15;
	localparam int          ADDR_W     = 8;
	localparam int          IDX_LSB    = 2;

	// test register fields
	localparam logic [15:0] TEST_RST   = 16'h010b;
	localparam int          POL_BIT    = 3;
	localparam int          FORCE_BIT  = 2;

	// enable bytes and implemented bits
	localparam logic [7:0]  EN_RST     = 8'h00;
	localparam logic [7:0]  FLAG_RST   = 8'h00;
	localparam logic [7:0]  PRI_MASK   = 8'hff;
	localparam logic [7:0]  SEC_MASK   = 8'hcf;

	// event counters
	localparam int          FCC_W      = 8;
	localparam int          REC_W      = 16;
	localparam logic [7:0]  FCC_HALF   = 8'h7f;
	localparam logic [15:0] REC_HALF   = 16'h7fff;

	// bus answers
	localparam logic [1:0]  RESP_OKAY  = 2'b00;
	localparam logic [1:0]  RESP_SLVERR = 2'b10;

	typedef enum logic {RD_IDLE, RD_DATA} pefi_rd_t;

	// primary event sources, msb first as laid out in the flag byte
	typedef struct packed {
		logic link_quality;
		logic energy;
		logic link_status;
		logic wake_frame;
		logic esd;
		logic training_done;
	} pefi_evt_t;

	typedef struct packed {
		logic undervolt;
		logic overvolt;
		logic overtemp;
		logic sleep;
		logic polarity;
		logic jabber;
	} pefi_sec_evt_t;
endpackage
`default_nettype wire

// ### pefi_flag_bank.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// latched-high flag byte, cleared by a read
// ************************************************************
module pefi_flag_bank
(
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	input  wire logic [7:0] present,
	input  wire logic [7:0] mask,
	input  wire logic       rd_clr,
	output var  logic [7:0] flags_reg
);
	logic [7:0] flags_next;

	genvar i;
	generate
		for (i = 0; i < 8; i++)
		begin : g_bit
			// a live event wins over the read clear
			always_comb
			begin
				flags_next[i] = mask[i] & (present[i] | (flags_reg[i] & ~rd_clr));
			end
		end
	endgenerate

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			flags_reg <= pefi_pkg::FLAG_RST;
		else
			flags_reg <= flags_next;
	end
endmodule
`default_nettype wire

// ### pefi_sat_counter.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// saturating event counter, clear on read, half-full level
// ************************************************************
module pefi_sat_counter
#(
	parameter int           W    = 8,
	parameter logic [W-1:0] HALF = '0
)
(
	input  wire logic         core_clk,
	input  wire logic         sys_rst,
	input  wire logic         inc,
	input  wire logic         rd_clr,
	output var  logic [W-1:0] count_reg,
	output var  logic         half
);
	logic [W-1:0] count_next;

	always_comb
	begin
		count_next = count_reg;
		// an event in the clearing cycle is kept as the first count
		if (rd_clr)
			count_next = inc ? W'(1) : '0;
		else if (inc && count_reg != {W{1'b1}})
			count_next = count_reg + W'(1);
		half = count_reg > HALF;
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			count_reg <= '0;
		else
			count_reg <= count_next;
	end
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	// ************************************************************
	// stimulus and observed signals
	// ************************************************************
	logic                    core_clk;
	logic                    sys_rst;
	pefi_pkg::pefi_evt_t     evt;
	pefi_pkg::pefi_sec_evt_t sec_evt;
	logic                    false_carrier_evt;
	logic                    rx_error_evt;
	logic                    int_pin_reg;
	logic [7:0]              s_axi_awaddr;
	logic                    s_axi_awvalid;
	logic                    s_axi_awready;
	logic [31:0]             s_axi_wdata;
	logic [3:0]              s_axi_wstrb;
	logic                    s_axi_wvalid;
	logic                    s_axi_wready;
	logic [1:0]              s_axi_bresp;
	logic                    s_axi_bvalid;
	logic                    s_axi_bready;
	logic [7:0]              s_axi_araddr;
	logic                    s_axi_arvalid;
	logic                    s_axi_arready;
	logic [31:0]             s_axi_rdata;
	logic [1:0]              s_axi_rresp;
	logic                    s_axi_rvalid;
	logic                    s_axi_rready;
	int                      err_total;
	int                      samples_checked;
	int                      cyc;
	logic [3:0]              wr_strb;

	pefi_flags dut_u
	(
		.core_clk, .sys_rst, .evt, .sec_evt, .false_carrier_evt, .rx_error_evt, .int_pin_reg,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
	);

	always #25 core_clk = ~core_clk;

	// runs about 33400 cycles; the ceiling leaves ample room
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			err_total++;
			report_and_stop();
		end
	end

	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic report_and_stop();
		if (err_total == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
			err_total++;
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
		logic aw_ok;
		logic w_ok;
		@(posedge core_clk);
		s_axi_awaddr  <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata   <= {16'h0000, d};
		s_axi_wstrb   <= wr_strb;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		aw_ok = 1'b0;
		w_ok  = 1'b0;
		while (!(aw_ok && w_ok))
		begin
			@(posedge core_clk);
			if (!aw_ok && s_axi_awready)
			begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_ok && s_axi_wready)
			begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (!s_axi_bvalid)
			@(posedge core_clk);
		s_axi_bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
	endtask

	task automatic axi_rd(input string nm, input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		@(posedge core_clk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		@(posedge core_clk);
		while (!s_axi_arready)
			@(posedge core_clk);
		s_axi_arvalid <= 1'b0;
		@(posedge core_clk);
		while (!s_axi_rvalid)
			@(posedge core_clk);
		s_axi_rready <= 1'b0;
		chk(nm, exp, s_axi_rdata);
		chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
	endtask

	task automatic pulse(input pefi_pkg::pefi_evt_t p, input pefi_pkg::pefi_sec_evt_t s);
		@(posedge core_clk);
		evt     <= p;
		sec_evt <= s;
		@(posedge core_clk);
		evt     <= '0;
		sec_evt <= '0;
	endtask

	// holds the pulse line high for n edges, one count per edge
	task automatic burst(input logic rx, input int n);
		@(posedge core_clk);
		if (rx)
			rx_error_evt <= 1'b1;
		else
			false_carrier_evt <= 1'b1;
		repeat (n) @(posedge core_clk);
		rx_error_evt      <= 1'b0;
		false_carrier_evt <= 1'b0;
	endtask

	// pin lags flags and test bits by one cycle; three edges leave margin
	task automatic pin_chk(input logic exp);
		repeat (3) @(posedge core_clk);
		#1;
		chk("int_pin", {31'h0, exp}, {31'h0, int_pin_reg});
	endtask

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_reset();
		axi_rd("test", 8'h44, 32'h0000010b, 2'b00);
		axi_rd("primary", 8'h48, 32'h0, 2'b00);
		axi_rd("secondary", 8'h4c, 32'h0, 2'b00);
		axi_rd("fc_count", 8'h50, 32'h0, 2'b00);
		axi_rd("rx_count", 8'h54, 32'h0, 2'b00);
		pin_chk(1'b1);
		axi_rd("unmapped", 8'h00, 32'h0, 2'b10);
		axi_wr(8'hfc, 16'hffff, 2'b10);
	endtask

	task automatic t_primary();
		axi_wr(8'h48, 16'hffff, 2'b00);
		axi_rd("pri_en", 8'h48, 32'h000000ff, 2'b00);
		for (int i = 0; i < 6; i++)
		begin
			pulse(6'h20 >> i, '0);
			axi_rd("pri_flag", 8'h48, 32'h000000ff | (32'h8000 >> i), 2'b00);
			axi_rd("pri_clr", 8'h48, 32'h000000ff, 2'b00);
		end
		axi_wr(8'h48, 16'h0000, 2'b00);
	endtask

	task automatic t_pin();
		axi_wr(8'h48, 16'h0080, 2'b00);
		pulse(6'h10, '0);
		pin_chk(1'b1);
		axi_rd("pri_en7", 8'h48, 32'h00004080, 2'b00);
		pulse(6'h20, '0);
		pin_chk(1'b0);
		axi_rd("pri_lq", 8'h48, 32'h00008080, 2'b00);
		pin_chk(1'b1);
		axi_wr(8'h44, 16'h0103, 2'b00);
		axi_rd("test_pol", 8'h44, 32'h00000103, 2'b00);
		pin_chk(1'b0);
		pulse(6'h20, '0);
		pin_chk(1'b1);
		axi_rd("pri_lq2", 8'h48, 32'h00008080, 2'b00);
		pin_chk(1'b0);
		axi_wr(8'h44, 16'h0107, 2'b00);
		repeat (4) pin_chk(1'b1);
		axi_wr(8'h44, 16'h010f, 2'b00);
		pin_chk(1'b0);
		axi_wr(8'h44, 16'h010b, 2'b00);
		pin_chk(1'b1);
		axi_wr(8'h48, 16'h0000, 2'b00);
	endtask

	task automatic t_hold();
		@(posedge core_clk);
		evt <= 6'h10;
		axi_rd("hold1", 8'h48, 32'h00004000, 2'b00);
		axi_rd("hold2", 8'h48, 32'h00004000, 2'b00);
		@(posedge core_clk);
		evt <= '0;
		axi_rd("hold3", 8'h48, 32'h00004000, 2'b00);
		axi_rd("hold4", 8'h48, 32'h0, 2'b00);
	endtask

	task automatic t_sec();
		axi_wr(8'h4c, 16'hffff, 2'b00);
		axi_rd("sec_en", 8'h4c, 32'h000000cf, 2'b00);
		pulse('0, 6'h3f);
		pin_chk(1'b0);
		axi_rd("sec_flag", 8'h4c, 32'h0000cfcf, 2'b00);
		axi_rd("sec_clr", 8'h4c, 32'h000000cf, 2'b00);
		pin_chk(1'b1);
		axi_wr(8'h4c, 16'h0000, 2'b00);
	endtask

	// only the strobed byte lanes may change
	task automatic t_strobe();
		wr_strb = 4'h2;
		axi_wr(8'h48, 16'h00ff, 2'b00);
		axi_rd("pri_strb", 8'h48, 32'h0, 2'b00);
		axi_wr(8'h44, 16'h02f7, 2'b00);
		axi_rd("test_strb", 8'h44, 32'h0000020b, 2'b00);
		wr_strb = 4'hf;
		axi_wr(8'h44, 16'h010b, 2'b00);
		axi_rd("test_back", 8'h44, 32'h0000010b, 2'b00);
	endtask

	task automatic t_counters();
		burst(1'b0, 127);
		axi_rd("fc_below", 8'h48, 32'h0, 2'b00);
		burst(1'b0, 1);
		axi_rd("fc_half", 8'h48, 32'h00000200, 2'b00);
		burst(1'b0, 200);
		axi_wr(8'h50, 16'h0055, 2'b00);
		axi_rd("fc_sat", 8'h50, 32'h000000ff, 2'b00);
		axi_rd("fc_cor", 8'h50, 32'h0, 2'b00);
		axi_rd("fc_latch", 8'h48, 32'h00000200, 2'b00);
		axi_rd("fc_gone", 8'h48, 32'h0, 2'b00);
		burst(1'b1, 32767);
		axi_rd("rx_below", 8'h48, 32'h0, 2'b00);
		burst(1'b1, 1);
		axi_rd("rx_count", 8'h54, 32'h00008000, 2'b00);
		axi_rd("rx_half", 8'h48, 32'h00000100, 2'b00);
		axi_rd("rx_gone", 8'h48, 32'h0, 2'b00);
	endtask

	// ************************************************************
	// main sequence
	// ************************************************************
	initial
	begin
		core_clk          = 1'b0;
		sys_rst           = 1'b1;
		evt               = '0;
		sec_evt           = '0;
		false_carrier_evt = 1'b0;
		rx_error_evt      = 1'b0;
		s_axi_awaddr      = 8'h00;
		s_axi_awvalid     = 1'b0;
		s_axi_wdata       = 32'h0;
		s_axi_wstrb       = 4'h0;
		s_axi_wvalid      = 1'b0;
		s_axi_bready      = 1'b0;
		s_axi_araddr      = 8'h00;
		s_axi_arvalid     = 1'b0;
		s_axi_rready      = 1'b0;
		err_total         = 0;
		samples_checked   = 0;
		cyc               = 0;
		wr_strb           = 4'hf;
		repeat (12) @(posedge core_clk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge core_clk);
		t_reset();
		t_primary();
		t_pin();
		t_hold();
		t_sec();
		t_strobe();
		t_counters();
		report_and_stop();
	end
endmodule
`default_nettype wire
